/* File: verilog/flash_host_cfg.svh */
/*
 Constants of the flash host controller: register offsets, field positions,
 reset values and bus timing counts. Assumes a 10 ns system clock.
*/
`ifndef FLASH_HOST_CFG_SVH
`define FLASH_HOST_CFG_SVH

// -----------------------------------------------------------------------------
// Register offsets (byte addresses)
// -----------------------------------------------------------------------------
`define FH_OFF_CTRL    8'h00
`define FH_OFF_ADDR    8'h04
`define FH_OFF_WDATA   8'h08
`define FH_OFF_CMD     8'h0C
`define FH_OFF_STATUS  8'h10
`define FH_OFF_RDATA   8'h14

// -----------------------------------------------------------------------------
// Field positions and reset values
// -----------------------------------------------------------------------------
`define FH_CTRL_WIDE   0
`define FH_CTRL_RUN    1
`define FH_CTRL_GATE   2
`define FH_CTRL_SEL    6:4
`define FH_CTRL_IDLE   10:8
`define FH_CTRL_RST    11'h700
`define FH_CMD_WR      0
`define FH_CMD_RD      1
`define FH_ST_BUSY     0
`define FH_ST_RDOK     1
`define FH_ST_WKOK     2
`define FH_ST_PIN      3
`define FH_ST_DONE     4
`define FH_ST_REF      5
`define FH_ADDR_MASK   24'hFFFFFF
`define FH_SYNC_W      17

// -----------------------------------------------------------------------------
// Timing
// -----------------------------------------------------------------------------
`define FH_CLK_NS      10
`define FH_T_WSET_NS   20
`define FH_T_WLOW_NS   70
`define FH_T_WHOLD_NS  20
`define FH_T_RACC_NS   150
`define FH_T_RESET_NS  500
`define FH_T_WAKE_NS   1000
`define FH_WSET_CYC    ((`FH_T_WSET_NS + `FH_CLK_NS - 1) / `FH_CLK_NS)
`define FH_WLOW_CYC    ((`FH_T_WLOW_NS + `FH_CLK_NS - 1) / `FH_CLK_NS)
`define FH_WHOLD_CYC   ((`FH_T_WHOLD_NS + `FH_CLK_NS - 1) / `FH_CLK_NS)
`define FH_RACC_CYC    ((`FH_T_RACC_NS + `FH_CLK_NS - 1) / `FH_CLK_NS)
`define FH_RESET_CYC   ((`FH_T_RESET_NS + `FH_CLK_NS - 1) / `FH_CLK_NS)
`define FH_WAKE_CYC    ((`FH_T_WAKE_NS + `FH_CLK_NS - 1) / `FH_CLK_NS)
`define FH_SYNC_CYC    4

`endif

/* File: verilog/flash_host_pkg.sv */
/*
 Types of the flash host controller.
 Assumes nothing of its surroundings.
*/
package flash_host_pkg;

    // -------------------------------------------------------------------------
    // Bus cycle sequencer
    // -------------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_WSET  = 3'h1,
        ST_WLOW  = 3'h3,
        ST_WHOLD = 3'h2,
        ST_RACC  = 3'h4,
        ST_RCAP  = 3'h5
    } bus_state_type;

endpackage : flash_host_pkg

/* File: verilog/sync_if.sv */
/*
 Carrier between the controller and its pin synchroniser.
 Assumes the constants header is on the include path.
*/
`timescale 1ns/10ps
`include "flash_host_cfg.svh"

interface sync_if;
    logic [`FH_SYNC_W-1:0] raw;
    logic [`FH_SYNC_W-1:0] clean;
    modport sync_side (input raw, output clean);
    modport user_side (output raw, input clean);
endinterface : sync_if

/* File: verilog/pin_sync.sv */
/*
 Three-stage synchroniser for the flash input pins; a change passes once
 the second and third stages agree. Assumes one clock and a synced reset.
*/
`timescale 1ns/10ps
`include "flash_host_cfg.svh"

module pin_sync (
    input wire logic clk,
    input wire logic rst_n,
    sync_if.sync_side port
);
    logic [`FH_SYNC_W-1:0] f1_q;
    logic [`FH_SYNC_W-1:0] f2_q;
    logic [`FH_SYNC_W-1:0] f3_q;
    logic [`FH_SYNC_W-1:0] clean_q;

    // -------------------------------------------------------------------------
    // Per-bit stages
    // -------------------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < `FH_SYNC_W; i++) begin : g_bit
            // Top bit is the pulled-up status pin: reset to its idle level
            localparam logic IDLE_LVL = (i == `FH_SYNC_W - 1);
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    f1_q[i]    <= IDLE_LVL;
                    f2_q[i]    <= IDLE_LVL;
                    f3_q[i]    <= IDLE_LVL;
                    clean_q[i] <= IDLE_LVL;
                end else begin
                    f1_q[i] <= port.raw[i];
                    f2_q[i] <= f1_q[i];
                    f3_q[i] <= f2_q[i];
                    if (f2_q[i] == f3_q[i]) begin
                        clean_q[i] <= f3_q[i];
                    end
                end
            end
        end
    endgenerate

    assign port.clean = clean_q;

endmodule : pin_sync

/* File: verilog/flash_host.sv */
/*
 Host controller for an asynchronous parallel NOR flash: register port for
 software, timed write and read cycles, reset/power-down sequencing and
 status pin watching. Assumes a 100 MHz clock and a pulled-up status pin.
*/
// Added by the designer: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
`include "flash_host_cfg.svh"

module flash_host
    import flash_host_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    output logic      [23:0] flash_addr,
    output logic      [15:0] data_out,
    output logic      [1:0]  data_oe,
    input  wire logic [15:0] data_in,
    output logic             we_n,
    output logic             oe_n,
    output logic             chip_select_0,
    output logic             chip_select_1,
    output logic             chip_select_2,
    output logic             width_sel_x16,
    output logic             reset_powerdown_n,
    input  wire logic        engine_state_pin
);
    logic          rst_s1_q;
    logic          rst_ok_q;
    logic [10:0]   ctrl_q;
    logic [23:0]   addr_reg_q;
    logic [15:0]   wdat_q;
    logic [15:0]   rword_q;
    logic          done_q;
    logic          ref_q;
    logic          sts_prev_q;
    logic          rp_q;
    logic [7:0]    rcnt_q;
    logic          read_ok_q;
    logic          wake_ok_q;
    bus_state_type st_q;
    logic [7:0]    cnt_q;
    logic [23:0]   addr_q;
    logic [15:0]   dout_q;
    logic [1:0]    oe_q;
    logic          we_n_q;
    logic          oe_n_q;
    logic [2:0]    cs_q;
    logic [31:0]   rdata_q;
    logic          busy;
    logic          sts;
    logic          cmd_hit;
    logic          go_wr;
    logic          go_rd;
    logic [23:0]   pin_addr;

    sync_if sif ();

    // -------------------------------------------------------------------------
    // Reset release
    // -------------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_s1_q <= 1'b0;
            rst_ok_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_ok_q <= rst_s1_q;
        end
    end

    // -------------------------------------------------------------------------
    // Pin synchroniser
    // -------------------------------------------------------------------------
    assign sif.raw = {engine_state_pin, data_in};

    pin_sync u_sync (
        .clk   (sys_clk),
        .rst_n (rst_ok_q),
        .port  (sif.sync_side)
    );

    assign sts = sif.clean[16];

    // -------------------------------------------------------------------------
    // Command decode
    // -------------------------------------------------------------------------
    assign busy    = (st_q != ST_IDLE);
    assign cmd_hit = reg_wr && (reg_addr == `FH_OFF_CMD);
    // Write only out of reset, after wake, and if gated only when ready
    assign go_wr = cmd_hit && reg_wdata[`FH_CMD_WR] && !reg_wdata[`FH_CMD_RD] && !busy
                   && rp_q && wake_ok_q
                   && !(ctrl_q[`FH_CTRL_GATE] && !sts);
    assign go_rd = cmd_hit && reg_wdata[`FH_CMD_RD] && !reg_wdata[`FH_CMD_WR] && !busy
                   && rp_q && read_ok_q;
    // Byte address in x8, word address on bits 23:1 in x16
    assign pin_addr = {addr_reg_q[23:1] & 23'(`FH_ADDR_MASK >> 1),
                       ctrl_q[`FH_CTRL_WIDE] ? 1'b0 : addr_reg_q[0]};

    // -------------------------------------------------------------------------
    // Software registers
    // -------------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_ok_q) begin
        if (!rst_ok_q) begin
            ctrl_q     <= `FH_CTRL_RST;
            addr_reg_q <= 24'h000000;
            wdat_q     <= 16'h0000;
        end else if (reg_wr) begin
            if (reg_addr == `FH_OFF_CTRL) begin
                ctrl_q <= reg_wdata[10:0];
            end
            if (reg_addr == `FH_OFF_ADDR) begin
                addr_reg_q <= reg_wdata[23:0];
            end
            if (reg_addr == `FH_OFF_WDATA) begin
                wdat_q <= reg_wdata[15:0];
            end
        end
    end

    // -------------------------------------------------------------------------
    // Sticky flags, set wins over clear
    // -------------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_ok_q) begin
        if (!rst_ok_q) begin
            sts_prev_q <= 1'b1;
            done_q     <= 1'b0;
            ref_q      <= 1'b0;
        end else begin
            sts_prev_q <= sts;
            // End of a busy level or of a completion pulse
            if (sts && !sts_prev_q) begin
                done_q <= 1'b1;
            end else if (reg_wr && reg_addr == `FH_OFF_STATUS && reg_wdata[`FH_ST_DONE]) begin
                done_q <= 1'b0;
            end
            if (cmd_hit && !go_wr && !go_rd) begin
                ref_q <= 1'b1;
            end else if (reg_wr && reg_addr == `FH_OFF_STATUS && reg_wdata[`FH_ST_REF]) begin
                ref_q <= 1'b0;
            end
        end
    end

    // -------------------------------------------------------------------------
    // Reset/power-down sequencing
    // -------------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_ok_q) begin
        if (!rst_ok_q) begin
            rp_q      <= 1'b0;
            rcnt_q    <= 8'h00;
            read_ok_q <= 1'b0;
            wake_ok_q <= 1'b0;
        end else if (!ctrl_q[`FH_CTRL_RUN] || !rp_q) begin
            rp_q      <= ctrl_q[`FH_CTRL_RUN];
            rcnt_q    <= 8'h00;
            read_ok_q <= 1'b0;
            wake_ok_q <= 1'b0;
        end else begin
            if (rcnt_q != 8'hFF) begin
                rcnt_q <= rcnt_q + 8'h01;
            end
            if (rcnt_q >= 8'(`FH_RESET_CYC - 1)) begin
                read_ok_q <= 1'b1;
            end
            if (rcnt_q >= 8'(`FH_WAKE_CYC - 1)) begin
                wake_ok_q <= 1'b1;
            end
        end
    end

    // -------------------------------------------------------------------------
    // Bus cycle sequencer
    // -------------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_ok_q) begin
        if (!rst_ok_q) begin
            st_q    <= ST_IDLE;
            cnt_q   <= 8'h00;
            addr_q  <= 24'h000000;
            dout_q  <= 16'h0000;
            oe_q    <= 2'h0;
            we_n_q  <= 1'b1;
            oe_n_q  <= 1'b1;
            cs_q    <= 3'h7;
            rword_q <= 16'h0000;
        end else begin
            unique case (st_q)
                ST_IDLE: begin
                    cs_q <= ctrl_q[`FH_CTRL_IDLE];
                    if (go_wr) begin
                        addr_q <= pin_addr;
                        dout_q <= wdat_q;
                        oe_q   <= ctrl_q[`FH_CTRL_WIDE] ? 2'h3 : 2'h1;
                        cs_q   <= ctrl_q[`FH_CTRL_SEL];
                        cnt_q  <= 8'(`FH_WSET_CYC - 1);
                        st_q   <= ST_WSET;
                    end else if (go_rd) begin
                        addr_q <= pin_addr;
                        cs_q   <= ctrl_q[`FH_CTRL_SEL];
                        oe_n_q <= 1'b0;
                        cnt_q  <= 8'(`FH_RACC_CYC + `FH_SYNC_CYC - 1);
                        st_q   <= ST_RACC;
                    end
                end
                ST_WSET: begin
                    cnt_q <= cnt_q - 8'h01;
                    if (cnt_q == 8'h00) begin
                        we_n_q <= 1'b0;
                        cnt_q  <= 8'(`FH_WLOW_CYC - 1);
                        st_q   <= ST_WLOW;
                    end
                end
                ST_WLOW: begin
                    cnt_q <= cnt_q - 8'h01;
                    if (cnt_q == 8'h00) begin
                        // Address and data stay put across the rising edge
                        we_n_q <= 1'b1;
                        cnt_q  <= 8'(`FH_WHOLD_CYC - 1);
                        st_q   <= ST_WHOLD;
                    end
                end
                ST_WHOLD: begin
                    cnt_q <= cnt_q - 8'h01;
                    if (cnt_q == 8'h00) begin
                        oe_q <= 2'h0;
                        cs_q <= ctrl_q[`FH_CTRL_IDLE];
                        st_q <= ST_IDLE;
                    end
                end
                ST_RACC: begin
                    cnt_q <= cnt_q - 8'h01;
                    if (cnt_q == 8'h00) begin
                        // High byte floats in x8 mode and reads as zero
                        rword_q <= ctrl_q[`FH_CTRL_WIDE] ? sif.clean[15:0]
                                                         : {8'h00, sif.clean[7:0]};
                        oe_n_q  <= 1'b1;
                        cs_q    <= ctrl_q[`FH_CTRL_IDLE];
                        st_q    <= ST_RCAP;
                    end
                end
                ST_RCAP: begin
                    st_q <= ST_IDLE;
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

    // -------------------------------------------------------------------------
    // Read port
    // -------------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_ok_q) begin
        if (!rst_ok_q) begin
            rdata_q <= 32'h00000000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `FH_OFF_CTRL:   rdata_q <= {21'h000000, ctrl_q};
                `FH_OFF_ADDR:   rdata_q <= {8'h00, addr_reg_q};
                `FH_OFF_WDATA:  rdata_q <= {16'h0000, wdat_q};
                `FH_OFF_STATUS: rdata_q <= {26'h0000000, ref_q, done_q, sts,
                                            wake_ok_q, read_ok_q, busy};
                `FH_OFF_RDATA:  rdata_q <= {16'h0000, rword_q};
                default:        rdata_q <= 32'h00000000;
            endcase
        end else begin
            rdata_q <= 32'h00000000;
        end
    end

    assign reg_rdata         = rdata_q;
    assign flash_addr        = addr_q;
    assign data_out          = dout_q;
    assign data_oe           = oe_q;
    assign we_n              = we_n_q;
    assign oe_n              = oe_n_q;
    assign chip_select_0     = cs_q[0];
    assign chip_select_1     = cs_q[1];
    assign chip_select_2     = cs_q[2];
    assign width_sel_x16     = ctrl_q[`FH_CTRL_WIDE];
    assign reset_powerdown_n = rp_q;

    // -------------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_ok_q);

    sequence s_engine_finish;
        !sts ##1 sts;
    endsequence
    sequence s_accept_wr;
        st_q == ST_IDLE ##1 st_q == ST_WSET;
    endsequence

    property p_we_pulse;
        $fell(we_n_q) |-> !we_n_q [*7] ##1 we_n_q;
    endproperty
    a_we_pulse: assert property (p_we_pulse) else $error("write strobe width wrong");
    property p_capture_stable;
        $rose(we_n_q) |-> $stable(addr_q) && $stable(dout_q) && oe_q != 2'h0;
    endproperty
    a_capture_stable: assert property (p_capture_stable) else $error("bus moved at strobe rise");
    property p_no_write_reset;
        $fell(we_n_q) |-> rp_q && wake_ok_q;
    endproperty
    a_no_write_reset: assert property (p_no_write_reset) else $error("write during reset or wake");
    property p_wake;
        $rose(wake_ok_q) |-> $past(rp_q, 100) && !$past(rp_q, 101);
    endproperty
    a_wake: assert property (p_wake) else $error("wake interval wrong");
    property p_read_ok;
        $rose(read_ok_q) |-> $past(rp_q, 50) && !$past(rp_q, 51);
    endproperty
    a_read_ok: assert property (p_read_ok) else $error("reset interval wrong");
    property p_x8;
        $fell(we_n_q) && !width_sel_x16 |-> oe_q == 2'h1 && addr_q[0] == addr_reg_q[0];
    endproperty
    a_x8: assert property (p_x8) else $error("byte mode bus wrong");
    property p_x16;
        $fell(we_n_q) && width_sel_x16 |-> oe_q == 2'h3 && addr_q[0] == 1'b0;
    endproperty
    a_x16: assert property (p_x16) else $error("word mode bus wrong");
    property p_done;
        s_engine_finish |=> done_q;
    endproperty
    a_done: assert property (p_done) else $error("completion not flagged");
    property p_gate;
        s_accept_wr |-> !ctrl_q[`FH_CTRL_GATE] || $past(sts);
    endproperty
    a_gate: assert property (p_gate) else $error("write issued while engine busy");
    property p_read_len;
        $fell(oe_n_q) |-> ##19 $rose(oe_n_q);
    endproperty
    a_read_len: assert property (p_read_len) else $error("read access length wrong");

endmodule : flash_host

/* File: tb/flash_model.sv */
/*
 Behavioural model of the flash device on the controller's pins.
 Assumes a pulled-up status pin resolved by the bench.
*/
`timescale 1ns/10ps

module flash_model #(
    parameter logic [7:0] GO_CODE   = 8'h20,
    parameter logic [7:0] LOCK_CODE = 8'h5A,
    parameter logic [7:0] SUSP_CODE = 8'hC3,
    parameter int         BUSY_NS   = 2000
) (
    input  wire logic [23:0] addr,
    input  wire logic [15:0] din,
    input  wire logic        we_n,
    input  wire logic        oe_n,
    input  wire logic        cs0,
    input  wire logic        cs1,
    input  wire logic        cs2,
    input  wire logic        x16,
    input  wire logic        rp_n,
    output logic      [15:0] dq,
    output logic             pin_low,
    output logic      [15:0] word_q,
    output logic      [23:0] addr_q
);
    logic         sel;
    logic         busy;
    logic         susp;
    logic [6:0]   blk;
    logic [127:0] lock_q;
    logic [15:0]  buf_q [16];
    logic [15:0]  cur;
    logic [15:0]  rd_val;
    logic [15:0]  last;
    // -------------------------------------------------------------------------
    // Command capture
    // -------------------------------------------------------------------------
    assign sel = ~cs0 & ~cs1 & ~cs2;
    initial begin
        busy = 1'b0;
        susp = 1'b0;
        blk = 7'h00;
        lock_q = 128'h0;
        addr_q = 24'h000000;
        last = 16'h0000;
        for (int i = 0; i < 16; i++) begin
            buf_q[i] = 16'h0000;
        end
    end
    always @(negedge rp_n) begin
        busy = 1'b0;
        susp = 1'b0;
    end
    always @(posedge busy) begin
        #BUSY_NS;
        busy = 1'b0;
    end
    always @(posedge we_n) begin
        if (sel && rp_n) begin
            addr_q = x16 ? {addr[23:1], 1'b0} : addr;
            if (busy) begin
                if (din[7:0] == SUSP_CODE) begin
                    busy = 1'b0;
                    susp = 1'b1;
                end
            end else if (din[7:0] == GO_CODE) begin
                if (!lock_q[addr[23:17]]) begin
                    blk = addr[23:17];
                    busy = 1'b1;
                end
            end else if (din[7:0] == LOCK_CODE) begin
                lock_q[addr[23:17]] = 1'b1;
            end else if (x16) begin
                buf_q[addr[4:1]] = din;
            end else if (addr[0]) begin
                buf_q[addr[4:1]][15:8] = din[7:0];
            end else begin
                buf_q[addr[4:1]][7:0] = din[7:0];
            end
        end
    end
    assign pin_low = busy & rp_n;
    assign word_q = buf_q[addr_q[4:1]];
    // -------------------------------------------------------------------------
    // Read drive; released lines show the inverse of the last value
    // -------------------------------------------------------------------------
    assign cur = buf_q[addr[4:1]];
    always @(posedge oe_n) begin
        last = rd_val;
    end
    always_comb begin
        if (busy) begin
            rd_val = {~last[15:8], 1'b0, ~last[6:0]};
        end else if (susp && addr[23:17] == blk) begin
            rd_val = ~last;
        end else if (x16) begin
            rd_val = cur;
        end else begin
            rd_val = {~last[15:8], addr[0] ? cur[15:8] : cur[7:0]};
        end
    end
    assign dq = (!oe_n && sel && rp_n) ? rd_val : ~last;
endmodule : flash_model

/* File: tb/testbench.sv */
/*
 Self-checking bench of the flash host controller through its register port.
 Assumes the design sources and the constants header are compiled first.
*/
`timescale 1ns/10ps
`include "flash_host_cfg.svh"

module testbench;
    import flash_host_pkg::*;
    logic sys_clk, rst_b, reg_wr, reg_rd, we_n, oe_n, c0, c1, c2, x16, rp_n, pin_low;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, d;
    logic [23:0] flash_addr, addr_q;
    logic [15:0] data_out, data_in, dq, word_q;
    logic [1:0]  data_oe;
    int          fails, tests_run;
    assign data_in[7:0] = data_oe[0] ? data_out[7:0] : dq[7:0];
    assign data_in[15:8] = data_oe[1] ? data_out[15:8] : dq[15:8];
    flash_host flash_host_i (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .flash_addr(flash_addr), .data_out(data_out), .data_oe(data_oe),
        .data_in(data_in), .we_n(we_n), .oe_n(oe_n), .chip_select_0(c0),
        .chip_select_1(c1), .chip_select_2(c2), .width_sel_x16(x16),
        .reset_powerdown_n(rp_n), .engine_state_pin(~pin_low));
    flash_model flash_model_i (.addr(flash_addr), .din(data_in), .we_n(we_n), .oe_n(oe_n),
        .cs0(c0), .cs1(c1), .cs2(c2), .x16(x16), .rp_n(rp_n), .dq(dq),
        .pin_low(pin_low), .word_q(word_q), .addr_q(addr_q));
    // -------------------------------------------------------------------------
    // Access tasks
    // -------------------------------------------------------------------------
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd
    task wait_st(input int b, input logic v);
        int n;
        n = 0;
        do begin
            rd(`FH_OFF_STATUS, d);
            n++;
        end while (d[b] !== v && n < 400);
        chk({31'h0, d[b]}, {31'h0, v});
    endtask : wait_st
    task cycle(input logic [23:0] a, input logic [15:0] v, input logic [31:0] c);
        wr(`FH_OFF_ADDR, {8'h00, a});
        wr(`FH_OFF_WDATA, {16'h0000, v});
        wr(`FH_OFF_CMD, c);
        wait_st(`FH_ST_BUSY, 1'b0);
    endtask : cycle
    task end_of_test;
        $display("fails %0d tests_run %0d", fails, tests_run);
        if (fails == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_of_test
    // -------------------------------------------------------------------------
    // Clock, reset, watchdog and tests
    // -------------------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        #300000;
        fails++;
        end_of_test;
    end
    initial begin
        fails = 0;
        tests_run = 0;
        rst_b = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h00000000;
        repeat (12) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rd(`FH_OFF_CTRL, d);
        chk(d, 32'h00000700);
        chk({31'h0, rp_n}, 32'h0);
        rd(8'h20, d);
        chk(d, 32'h00000000);
        wr(`FH_OFF_CTRL, 32'h00000706);
        rd(`FH_OFF_STATUS, d);
        chk({30'h0, d[2:1]}, 32'h0);
        wait_st(`FH_ST_RDOK, 1'b1);
        wait_st(`FH_ST_WKOK, 1'b1);
        cycle(24'h000001, 16'h00A5, 32'h1);
        chk({8'h00, addr_q}, 32'h00000001);
        cycle(24'h000001, 16'h0000, 32'h2);
        rd(`FH_OFF_RDATA, d);
        chk(d, 32'h000000A5);
        wr(`FH_OFF_CTRL, 32'h00000707);
        cycle(24'h000013, 16'h1234, 32'h1);
        chk({8'h00, addr_q}, 32'h00000012);
        cycle(24'h000013, 16'h0000, 32'h2);
        rd(`FH_OFF_RDATA, d);
        chk(d, 32'h00001234);
        cycle(24'h000040, 16'h0020, 32'h1);
        wait_st(`FH_ST_PIN, 1'b0);
        wr(`FH_OFF_CMD, 32'h1);
        rd(`FH_OFF_STATUS, d);
        chk({31'h0, d[`FH_ST_REF]}, 32'h1);
        wait_st(`FH_ST_DONE, 1'b1);
        wr(`FH_OFF_STATUS, 32'h00000030);
        rd(`FH_OFF_STATUS, d);
        chk(d, 32'h0000000E);
        cycle(24'h020000, 16'h005A, 32'h1);
        cycle(24'h020000, 16'h0020, 32'h1);
        rd(`FH_OFF_STATUS, d);
        chk({31'h0, d[`FH_ST_PIN]}, 32'h1);
        wr(`FH_OFF_CTRL, 32'h00000703);
        cycle(24'h000040, 16'h0020, 32'h1);
        wait_st(`FH_ST_PIN, 1'b0);
        cycle(24'h000040, 16'h00C3, 32'h1);
        cycle(24'h020013, 16'h0000, 32'h2);
        rd(`FH_OFF_RDATA, d);
        chk(d, 32'h00001234);
        wait_st(`FH_ST_PIN, 1'b1);
        wr(`FH_OFF_CTRL, 32'h00000704);
        rd(`FH_OFF_STATUS, d);
        chk({30'h0, d[2:1]}, 32'h0);
        chk({31'h0, rp_n}, 32'h0);
        end_of_test;
    end
endmodule : testbench
